/* File: verilog/edge_irq_pkg.sv */
/*
  Package for the extended edge interrupt flag block: register byte
  addresses, field positions, reset values and bus widths.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package edge_irq_pkg;
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          NUM_IRQ        = 4;
  // Printed offsets are not multiples of four, so they are indices.
  localparam logic [7:0]  FLAGS_IDX      = 8'h91;
  localparam logic [7:0]  CFG_LOW_IDX    = 8'h92;
  localparam logic [7:0]  CFG_HIGH_IDX   = 8'h93;
  localparam logic [7:0]  IRQ_EN_IDX     = 8'h94;
  localparam logic [7:0]  IRQ_CLR_IDX    = 8'h95;
  localparam logic [7:0]  PIN_STATE_IDX  = 8'h96;
  localparam logic [11:0] FLAGS_ADDR     = {2'h0, FLAGS_IDX, 2'h0};
  localparam logic [11:0] CFG_LOW_ADDR   = {2'h0, CFG_LOW_IDX, 2'h0};
  localparam logic [11:0] CFG_HIGH_ADDR  = {2'h0, CFG_HIGH_IDX, 2'h0};
  localparam logic [11:0] IRQ_EN_ADDR    = {2'h0, IRQ_EN_IDX, 2'h0};
  localparam logic [11:0] IRQ_CLR_ADDR   = {2'h0, IRQ_CLR_IDX, 2'h0};
  localparam logic [11:0] PIN_STATE_ADDR = {2'h0, PIN_STATE_IDX, 2'h0};
  // Flags sit in bits 7:4: bit 7 irq5, 6 irq4, 5 irq3, 4 irq2.
  localparam int          FLAG_LSB       = 4;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [3:0]  FLAG_RESET     = 4'h0;
  localparam logic [3:0]  EN_RESET       = 4'h0;
  // Per input: 1 selects falling edge (active-low pin), 0 rising.
  localparam logic [3:0]  FALLING_SEL    = 4'hA;
endpackage

/* File: verilog/edge_irq_if.sv */
/*
  Interface between the register block and the edge detector.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
interface edge_irq_if;
  logic [3:0] edge_hit;   // One-cycle pulses of detected edges.
  logic [3:0] pin_level;  // Synchronised pin levels.
  modport detector (output edge_hit, output pin_level);
  modport regs     (input edge_hit, input pin_level);
endinterface

/* File: verilog/edge_detect.sv */
/*
  Synchroniser and edge detector for the four extra interrupt pins.
  Assumes asynchronous pin inputs and one clock pclk.
*/
`timescale 1ns/1ps
module edge_detect
  import edge_irq_pkg::*;
(
  input  wire logic       pclk,     // Core clock.
  input  wire logic       presetn,  // Asynchronous reset, active low.
  input  wire logic [3:0] pins,     // Raw pins, index 3 = irq5 .. 0 = irq2.
  edge_irq_if.detector    det       // Edge pulses and levels.
);
  logic [3:0] meta_reg, meta_next;
  logic [3:0] sync_reg, sync_next;
  logic [3:0] prev_reg, prev_next;

  always_comb begin
    meta_next = pins;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle level: low-active pins rest high, high-active rest low.
      meta_reg <= FALLING_SEL;
      sync_reg <= FALLING_SEL;
      prev_reg <= FALLING_SEL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // Edges compare synchronised samples only.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (FALLING_SEL[i]) begin
        det.edge_hit[i] = prev_reg[i] & ~sync_reg[i];
      end else begin
        det.edge_hit[i] = ~prev_reg[i] & sync_reg[i];
      end
    end
    det.pin_level = sync_reg;
  end
endmodule

/* File: verilog/extended_edge_interrupt_flags.sv */
/*
  Extended edge interrupt flags: four extra external interrupt inputs
  latch sticky flags readable and clearable over APB, with enable and
  write-one-to-clear registers and one level interrupt output.
  Assumes an APB master on pclk and asynchronous pins.
*/
`timescale 1ns/1ps
module extended_edge_interrupt_flags
  import edge_irq_pkg::*;
(
  input  wire logic                          pclk,           // Core clock, 100 MHz.
  input  wire logic                          presetn,        // Async reset, active low.
  input  wire logic                          psel,           // APB select.
  input  wire logic                          penable,        // APB access phase.
  input  wire logic                          pwrite,         // APB write.
  input  wire logic [edge_irq_pkg::ADDR_W-1:0] paddr,        // APB byte address.
  input  wire logic [edge_irq_pkg::DATA_W-1:0] pwdata,       // APB write data.
  input  wire logic [3:0]                    pstrb,          // APB byte strobes.
  output logic      [edge_irq_pkg::DATA_W-1:0] prdata,       // APB read data.
  output logic                               pready,         // APB ready.
  output logic                               pslverr,        // APB error.
  input  wire logic                          ext_irq5_pin_n, // Irq5, falling edge.
  input  wire logic                          ext_irq4_pin,   // Irq4, rising edge.
  input  wire logic                          ext_irq3_pin_n, // Irq3, falling edge.
  input  wire logic                          ext_irq2_pin,   // Irq2, rising edge.
  output logic                               irq             // Level interrupt.
);
  edge_irq_if link ();

  logic [3:0] flags_reg, flags_next;
  logic [3:0] en_reg,    en_next;
  logic [7:0] cfg_lo_reg, cfg_lo_next;
  logic [7:0] cfg_hi_reg, cfg_hi_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic       irq_reg, irq_next;
  logic       wr_acc, rd_acc, hit, lane0;
  logic [3:0] clr_mask;

  edge_detect u_det (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    ({ext_irq5_pin_n, ext_irq4_pin, ext_irq3_pin_n, ext_irq2_pin}),
    .det     (link.detector)
  );

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a == FLAGS_ADDR) || (a == CFG_LOW_ADDR) || (a == CFG_HIGH_ADDR) ||
           (a == IRQ_EN_ADDR) || (a == IRQ_CLR_ADDR) || (a == PIN_STATE_ADDR);
  endfunction

  // Zero wait states: the access phase always completes.
  assign pready  = 1'b1;
  assign hit     = addr_known(paddr);
  assign wr_acc  = psel & penable & pwrite & hit;
  assign rd_acc  = psel & ~pwrite & hit;
  assign pslverr = psel & penable & ~hit;
  assign lane0   = pstrb[0];
  assign prdata  = rdata_reg;
  assign irq     = irq_reg;

  always_comb begin
    clr_mask    = 4'h0;
    en_next     = en_reg;
    cfg_lo_next = cfg_lo_reg;
    cfg_hi_next = cfg_hi_reg;
    if (wr_acc && lane0) begin
      case (paddr)
        // Writing zero to a flag bit clears it; writing one leaves it.
        FLAGS_ADDR:    clr_mask = ~pwdata[FLAG_LSB +: 4];
        IRQ_CLR_ADDR:  clr_mask = pwdata[FLAG_LSB +: 4];
        IRQ_EN_ADDR:   en_next = pwdata[FLAG_LSB +: 4];
        CFG_LOW_ADDR:  cfg_lo_next = pwdata[7:0];
        CFG_HIGH_ADDR: cfg_hi_next = pwdata[7:0];
        default:       clr_mask = 4'h0;
      endcase
    end
    // A new edge wins over a clear in the same cycle.
    flags_next = (flags_reg & ~clr_mask) | link.edge_hit;
    irq_next   = |(flags_next & en_next);
  end

  // Read data is captured in setup so it is valid in the access phase.
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_acc && !penable) begin
      rdata_next = '0;
      case (paddr)
        FLAGS_ADDR:     rdata_next[7:0] = {flags_reg, 4'h0};
        IRQ_EN_ADDR:    rdata_next[7:0] = {en_reg, 4'h0};
        CFG_LOW_ADDR:   rdata_next[7:0] = cfg_lo_reg;
        CFG_HIGH_ADDR:  rdata_next[7:0] = cfg_hi_reg;
        PIN_STATE_ADDR: rdata_next[7:0] = {link.pin_level, 4'h0};
        default:        rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg  <= FLAG_RESET;
      en_reg     <= EN_RESET;
      cfg_lo_reg <= CFG_RESET;
      cfg_hi_reg <= CFG_RESET;
      rdata_reg  <= '0;
      irq_reg    <= 1'b0;
    end else begin
      flags_reg  <= flags_next;
      en_reg     <= en_next;
      cfg_lo_reg <= cfg_lo_next;
      cfg_hi_reg <= cfg_hi_next;
      rdata_reg  <= rdata_next;
      irq_reg    <= irq_next;
    end
  end

  // Assertions.
  irq5_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(u_det.sync_reg[3]) |=> flags_reg[3])
    else $error("irq5 falling edge did not set flag");
  irq4_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(u_det.sync_reg[2]) |=> flags_reg[2])
    else $error("irq4 rising edge did not set flag");
  irq3_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(u_det.sync_reg[1]) |=> flags_reg[1])
    else $error("irq3 falling edge did not set flag");
  irq2_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(u_det.sync_reg[0]) |=> flags_reg[0])
    else $error("irq2 rising edge did not set flag");
  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|flags_reg) && !wr_acc |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
    else $error("flag dropped without a clear");
  flag_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flags_reg[3]) |-> $past(u_det.prev_reg[3]) && !$past(u_det.sync_reg[3]))
    else $error("irq5 flag set without a falling edge");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|(flags_reg & en_reg)) == irq)
    else $error("irq output disagrees with enabled flags");
  no_glitch_a: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(u_det.sync_reg) && $stable(u_det.prev_reg) && !wr_acc
      |=> $stable(flags_reg))
    else $error("flags changed with no edge and no write");

  set_cv: cover property (@(posedge pclk) disable iff (!presetn) $rose(flags_reg[3]));
  irq_cv: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  clr_cv: cover property (@(posedge pclk) disable iff (!presetn)
    wr_acc && (paddr == IRQ_CLR_ADDR) && (|flags_reg));
endmodule

/* File: sim/pin_source.sv */
/*
  Behavioural source for the four extra interrupt pins.
  Assumes the bench sets the requested levels just after pclk edges.
*/
`timescale 1ns/1ps
module pin_source (
  input  wire logic       pclk,    // Bench clock.
  input  wire logic       presetn, // Reset, active low.
  input  wire logic [3:0] req,     // Requested pin levels.
  output logic      [3:0] pins     // Pin levels, idle during reset.
);
  // Pins rest at their idle levels in reset so that no false edge appears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= 4'hA;
    end else begin
      pins <= req;
    end
  end
endmodule

/* File: sim/tb_top.sv */
/*
  Self-checking bench for the edge interrupt flags with a reference model.
  Assumes the pin source model and the design package are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import edge_irq_pkg::*;
  logic              pclk = 0;
  logic              presetn = 0;
  logic              psel = 0;
  logic              penable = 0;
  logic              pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rd;
  logic [3:0]        pstrb = 4'hF;
  logic [3:0]        req = 4'hA;
  logic [3:0]        pins;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              err;
  logic [3:0]        fl = 4'h0;
  logic [3:0]        en = 4'h0;
  logic [3:0]        t;
  logic [3:0]        act;
  int                num_errors = 0;
  int                check_count = 0;
  int                seed = 16598;
  always #5 pclk = ~pclk;
  pin_source src (.pclk(pclk), .presetn(presetn), .req(req), .pins(pins));
  extended_edge_interrupt_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq5_pin_n(pins[3]),
    .ext_irq4_pin(pins[2]), .ext_irq3_pin_n(pins[1]), .ext_irq2_pin(pins[0]), .irq(irq));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk("pready", 1, pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FLAGS_ADDR, 0);
    chk("flags reset", 0, rd);
    apb(1'b0, 12'h000, 0);
    chk("unmapped error", 1, err);
    t = $random(seed);
    apb(1'b1, CFG_LOW_ADDR, {24'h0, t, ~t});
    apb(1'b0, CFG_LOW_ADDR, 0);
    chk("cfg_low", {24'h0, t, ~t}, rd);
    t = $random(seed);
    apb(1'b1, CFG_HIGH_ADDR, {24'h0, ~t, t});
    apb(1'b0, CFG_HIGH_ADDR, 0);
    chk("cfg_high", {24'h0, ~t, t}, rd);
    apb(1'b0, IRQ_CLR_ADDR, 0);
    chk("irq_clear reads zero", 0, rd);
    for (int i = 0; i < 40; i++) begin
      t = $random(seed);
      // Irq5 and irq3 count falling edges, irq4 and irq2 rising edges.
      act = (4'hA & req & ~t) | (4'h5 & ~req & t);
      fl = fl | act;
      req <= t;
      repeat (6) @(posedge pclk);
      apb(1'b0, FLAGS_ADDR, 0);
      chk("flags", {24'h0, fl, 4'h0}, rd);
      chk("irq", |(fl & en), irq);
      apb(1'b0, PIN_STATE_ADDR, 0);
      chk("pin_state", {24'h0, req, 4'h0}, rd);
      t = $random(seed);
      if (i % 3 == 0) begin
        apb(1'b1, FLAGS_ADDR, {24'h0, ~t, 4'h0});
        fl = fl & ~t;
      end else if (i % 3 == 1) begin
        apb(1'b1, IRQ_CLR_ADDR, {24'h0, t, 4'h0});
        fl = fl & ~t;
      end else begin
        apb(1'b1, IRQ_EN_ADDR, {24'h0, t, 4'h0});
        en = t;
      end
    end
    report_and_stop();
  end
endmodule
